// ---- rtl/nvsram_host.sv ----
`default_nettype none
module nvsram_host
	import nvsram_pkg::*;
#(
	parameter int POWERUP_CYC = POWERUP_RELOAD_CYC,
	parameter int SAVE_CYC    = SAVE_DURATION_CYC
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              CMD_VALID,
	output logic                   CMD_READY,
	input  wire logic [2:0]        CMD_OP,
	input  wire logic [ADDR_W-1:0] CMD_ADDR,
	input  wire logic [DATA_W-1:0] CMD_WDATA,
	output logic                   RSP_VALID,
	output logic      [DATA_W-1:0] RSP_RDATA,
	output logic      [ADDR_W-1:0] MEM_ADDR,
	output logic                   MEM_SEL_N,
	output logic                   MEM_WE_N,
	output logic                   MEM_OE_N,
	input  wire logic [DATA_W-1:0] MEM_DQ_IN,
	output logic      [DATA_W-1:0] MEM_DQ_OUT,
	output logic                   MEM_DQ_OE,
	input  wire logic              BUSY_LINE_IN,
	output logic                   BUSY_LINE_OUT,
	output logic                   BUSY_LINE_OE
);

	// ------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------
	logic [DATA_W-1:0] dq_sync;
	logic              busy_high;

	pin_sync #(
		.WIDTH (DATA_W + 1)
	) u_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in ({BUSY_LINE_IN, MEM_DQ_IN}),
		.sync_out ({busy_high, dq_sync})
	);

	// ------------------------------------------------------------
	// Controller state.
	// ------------------------------------------------------------
	state_t             state;
	state_t             next_state;
	logic [CNT_W-1:0]   cnt;
	logic [CNT_W-1:0]   next_cnt;
	logic [2:0]         ph;
	logic [2:0]         next_ph;
	logic [2:0]         step;
	logic [2:0]         next_step;
	logic [2:0]         op;
	logic [2:0]         next_op;
	logic               owed;
	logic               next_owed;
	logic               next_rsp_valid;
	logic [DATA_W-1:0]  next_rdata;
	logic [ADDR_W-1:0]  next_addr;
	logic               next_sel_n;
	logic               next_we_n;
	logic               next_oe_n;
	logic [DATA_W-1:0]  next_dq_out;
	logic               next_dq_oe;
	logic               next_busy_oe;
	logic               is_seq;
	logic               is_write;

	assign is_seq        = (op == OP_SAVE) || (op == OP_RELOAD);
	assign is_write      = (op == OP_WRITE);
	assign BUSY_LINE_OUT = 1'b0;
	assign CMD_READY     = (state == ST_IDLE) && busy_high;

	always_comb
	begin
		next_state     = state;
		next_cnt       = cnt;
		next_ph        = ph;
		next_step      = step;
		next_op        = op;
		next_owed      = owed;
		next_rsp_valid = 1'b0;
		next_rdata     = RSP_RDATA;
		next_addr      = MEM_ADDR;
		next_sel_n     = MEM_SEL_N;
		next_we_n      = MEM_WE_N;
		next_oe_n      = MEM_OE_N;
		next_dq_out    = MEM_DQ_OUT;
		next_dq_oe     = MEM_DQ_OE;
		next_busy_oe   = BUSY_LINE_OE;
		case (state)
			ST_POWERUP:
			begin
				if (cnt == '0)
					next_state = ST_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			ST_IDLE:
			begin
				if (!busy_high)
				begin
					next_state = ST_LINEWAIT;
					next_owed  = 1'b0;
				end
				else if (CMD_VALID)
				begin
					next_op     = CMD_OP;
					next_owed   = 1'b1;
					next_step   = 3'h0;
					next_ph     = PH_SETUP;
					next_dq_out = CMD_WDATA;
					if (CMD_OP == OP_HWSAVE)
					begin
						next_state   = ST_HOLDLINE;
						next_cnt     = GRACE_TIME_CNT;
						next_busy_oe = 1'b1;
					end
					else if ((CMD_OP == OP_SAVE) || (CMD_OP == OP_RELOAD))
					begin
						next_addr  = seq_addr(3'h0, CMD_OP == OP_RELOAD);
						next_state = ST_ACCESS;
					end
					else
					begin
						next_addr  = CMD_ADDR;
						next_state = ST_ACCESS;
					end
				end
			end
			ST_ACCESS:
			begin
				case (ph)
					PH_SETUP:
					begin
						next_sel_n = 1'b0;
						next_oe_n  = is_write;
						next_we_n  = !is_write;
						next_dq_oe = is_write;
						next_ph    = ph + 3'h1;
					end
					PH_CLOSE:
					begin
						next_sel_n = 1'b1;
						next_we_n  = 1'b1;
						next_oe_n  = 1'b1;
						next_ph    = PH_END;
					end
					PH_END:
					begin
						next_dq_oe = 1'b0;
						next_ph    = PH_SETUP;
						if (is_seq)
						begin
							if (step == SEQ_LAST_STEP)
							begin
								next_state = ST_NVWAIT;
								next_cnt   = (op == OP_RELOAD) ? RELOAD_DURATION_CNT
								                               : CNT_W'(SAVE_CYC);
							end
							else
							begin
								next_step = step + 3'h1;
								next_addr = seq_addr(step + 3'h1, op == OP_RELOAD);
							end
						end
						else
						begin
							if (!is_write)
								next_rdata = dq_sync;
							next_rsp_valid = 1'b1;
							next_owed      = 1'b0;
							next_state     = ST_IDLE;
						end
					end
					default:
						next_ph = ph + 3'h1;
				endcase
			end
			ST_NVWAIT:
			begin
				if (cnt == '0)
					next_state = ST_LINEWAIT;
				else
					next_cnt = cnt - 1'b1;
			end
			ST_HOLDLINE:
			begin
				// line held for the grace time
				if (cnt == '0)
				begin
					next_busy_oe = 1'b0;
					next_state   = ST_LINEWAIT;
				end
				else
					next_cnt = cnt - 1'b1;
			end
			ST_LINEWAIT:
			begin
				if (busy_high)
				begin
					next_state     = ST_IDLE;
					next_rsp_valid = owed;
					next_owed      = 1'b0;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			state        <= ST_POWERUP;
			cnt          <= CNT_W'(POWERUP_CYC);
			ph           <= PH_SETUP;
			step         <= 3'h0;
			op           <= OP_READ;
			owed         <= 1'b0;
			RSP_VALID    <= 1'b0;
			RSP_RDATA    <= 8'h00;
			MEM_ADDR     <= 13'h0000;
			MEM_SEL_N    <= 1'b1;
			MEM_WE_N     <= 1'b1;
			MEM_OE_N     <= 1'b1;
			MEM_DQ_OUT   <= 8'h00;
			MEM_DQ_OE    <= 1'b0;
			BUSY_LINE_OE <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			cnt          <= next_cnt;
			ph           <= next_ph;
			step         <= next_step;
			op           <= next_op;
			owed         <= next_owed;
			RSP_VALID    <= next_rsp_valid;
			RSP_RDATA    <= next_rdata;
			MEM_ADDR     <= next_addr;
			MEM_SEL_N    <= next_sel_n;
			MEM_WE_N     <= next_we_n;
			MEM_OE_N     <= next_oe_n;
			MEM_DQ_OUT   <= next_dq_out;
			MEM_DQ_OE    <= next_dq_oe;
			BUSY_LINE_OE <= next_busy_oe;
		end
	end

endmodule // nvsram_host
`default_nettype wire

// ---- rtl/nvsram_pkg.sv ----
`default_nettype none
package nvsram_pkg;

	// ------------------------------------------------------------
	// Widths of the memory pins and of the time counter.
	// ------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 18;

	// ------------------------------------------------------------
	// Command codes of the user port.
	// ------------------------------------------------------------
	localparam logic [2:0] OP_READ   = 3'h0;
	localparam logic [2:0] OP_WRITE  = 3'h1;
	localparam logic [2:0] OP_SAVE   = 3'h2;
	localparam logic [2:0] OP_RELOAD = 3'h3;
	localparam logic [2:0] OP_HWSAVE = 3'h4;

	// ------------------------------------------------------------
	// Addresses of the six-read software sequence.
	// ------------------------------------------------------------
	localparam logic [12:0] SEQ_ADDR_0      = 13'h0000;
	localparam logic [12:0] SEQ_ADDR_1      = 13'h1555;
	localparam logic [12:0] SEQ_ADDR_2      = 13'h0AAA;
	localparam logic [12:0] SEQ_ADDR_3      = 13'h1FFF;
	localparam logic [12:0] SEQ_ADDR_4      = 13'h10F0;
	localparam logic [12:0] SEQ_ADDR_SAVE   = 13'h0F0F;
	localparam logic [12:0] SEQ_ADDR_RELOAD = 13'h0F0E;
	localparam logic [2:0]  SEQ_LAST_STEP   = 3'h5;

	// ------------------------------------------------------------
	// Phases of one framed memory cycle.
	// ------------------------------------------------------------
	localparam logic [2:0] PH_SETUP  = 3'h0;
	localparam logic [2:0] PH_STROBE = 3'h1;
	localparam logic [2:0] PH_CLOSE  = 3'h3;
	localparam logic [2:0] PH_END    = 3'h4;

	// ------------------------------------------------------------
	// Times and the cycle counts derived from them.
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 40;
	localparam int POWERUP_RELOAD_US   = 550;
	localparam int SAVE_DURATION_MS    = 10;
	localparam int RELOAD_DURATION_US  = 20;
	localparam int GRACE_TIME_US       = 1;
	localparam int POWERUP_RELOAD_CYC  =
		(POWERUP_RELOAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAVE_DURATION_CYC   =
		(SAVE_DURATION_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELOAD_DURATION_CYC =
		(RELOAD_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRACE_TIME_CYC      =
		(GRACE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] RELOAD_DURATION_CNT = CNT_W'(RELOAD_DURATION_CYC);
	localparam logic [CNT_W-1:0] GRACE_TIME_CNT      = CNT_W'(GRACE_TIME_CYC);

	// ------------------------------------------------------------
	// Controller states.
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_POWERUP  = 6'b000001,
		ST_IDLE     = 6'b000010,
		ST_ACCESS   = 6'b000100,
		ST_NVWAIT   = 6'b001000,
		ST_HOLDLINE = 6'b010000,
		ST_LINEWAIT = 6'b100000
	} state_t;

	function automatic logic [12:0] seq_addr(input logic [2:0] step, input logic reload);
		logic [12:0] a;
		a = SEQ_ADDR_0;
		case (step)
			3'h1: a = SEQ_ADDR_1;
			3'h2: a = SEQ_ADDR_2;
			3'h3: a = SEQ_ADDR_3;
			3'h4: a = SEQ_ADDR_4;
			3'h5: a = reload ? SEQ_ADDR_RELOAD : SEQ_ADDR_SAVE;
			default: a = SEQ_ADDR_0;
		endcase
		return a;
	endfunction

endpackage
`default_nettype wire

// ---- rtl/pin_sync.sv ----
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------
	// Two flip-flops per bit before any logic looks at a pin.
	// ------------------------------------------------------------
	logic [WIDTH-1:0] first;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					first[i]    <= 1'b1;
					sync_out[i] <= 1'b1;
				end
				else
				begin
					first[i]    <= async_in[i];
					sync_out[i] <= first[i];
				end
			end
		end
	endgenerate

endmodule // pin_sync
`default_nettype wire

// ---- tb/nvsram_host_monitor.sv ----
`default_nettype none
module nvsram_host_monitor
	import nvsram_pkg::*;
(
	input wire logic              CORE_CLK,
	input wire logic              RST,
	input wire logic              CMD_VALID,
	input wire logic              CMD_READY,
	input wire logic [2:0]        CMD_OP,
	input wire logic              RSP_VALID,
	input wire logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic              MEM_SEL_N,
	input wire logic              MEM_WE_N,
	input wire logic              MEM_OE_N,
	input wire logic              MEM_DQ_OE,
	input wire logic              BUSY_LINE_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	sequence step(logic [12:0] a);
		!MEM_SEL_N && MEM_WE_N && MEM_ADDR == a;
	endsequence

	sequence six(logic [12:0] last);
		step(SEQ_ADDR_0) ##5 step(SEQ_ADDR_1) ##5 step(SEQ_ADDR_2) ##5 step(SEQ_ADDR_3)
			##5 step(SEQ_ADDR_4) ##5 step(last);
	endsequence

	save_seq_a: assert property (
		CMD_VALID && CMD_READY && CMD_OP == OP_SAVE |-> ##3 six(SEQ_ADDR_SAVE))
		else $error("save read sequence wrong");
	reload_seq_a: assert property (
		CMD_VALID && CMD_READY && CMD_OP == OP_RELOAD |-> ##3 six(SEQ_ADDR_RELOAD))
		else $error("reload read sequence wrong");
	sel_frame_a: assert property (
		$fell(MEM_SEL_N) |-> (!MEM_SEL_N)[*3] ##1 MEM_SEL_N)
		else $error("select frame wrong");
	addr_hold_a: assert property (
		!MEM_SEL_N && !$past(MEM_SEL_N) |-> $stable(MEM_ADDR))
		else $error("address moved under select");
	read_mode_a: assert property (
		$fell(MEM_OE_N) |-> !MEM_SEL_N && MEM_WE_N && !MEM_DQ_OE)
		else $error("read strobes wrong");
	write_oe_a: assert property (
		!MEM_WE_N |-> MEM_OE_N && MEM_DQ_OE)
		else $error("write drive wrong");
	rsp_time_a: assert property (
		CMD_VALID && CMD_READY && CMD_OP <= OP_WRITE |-> ##6 RSP_VALID)
		else $error("access answer late");
	grace_hold_a: assert property (
		$rose(BUSY_LINE_OE) |-> ##25 BUSY_LINE_OE ##1 !BUSY_LINE_OE)
		else $error("busy pulse length wrong");
	busy_quiet_a: assert property (
		BUSY_LINE_OE |-> MEM_SEL_N)
		else $error("access while busy pulled");
	powerup_a: assert property (
		$fell(RST) |-> (!CMD_READY)[*8])
		else $error("ready during power-up");
endmodule // nvsram_host_monitor

bind nvsram_host nvsram_host_monitor MON (.CORE_CLK, .RST, .CMD_VALID, .CMD_READY, .CMD_OP,
	.RSP_VALID, .MEM_ADDR, .MEM_SEL_N, .MEM_WE_N, .MEM_OE_N, .MEM_DQ_OE, .BUSY_LINE_OE);
`default_nettype wire

// ---- tb/nvsram_dev_model.sv ----
`default_nettype none
module nvsram_dev_model
	import nvsram_pkg::*;
#(
	parameter int SAVE_T = 60,
	parameter int LOAD_T = 10
) (
	input wire logic              clk,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              sel_n,
	input wire logic              we_n,
	input wire logic              oe_n,
	input wire logic [DATA_W-1:0] dq_host,
	input wire logic              busy,
	output logic      [DATA_W-1:0] dq_dev,
	output logic                  dq_dev_oe,
	output logic                  busy_dev_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] ram [0:8191];
	logic [DATA_W-1:0] nv  [0:8191];
	logic [12:0]       tab [0:4];
	logic              sel_q, we_q, busy_q, wr;
	int                step, t, saves, skips, loads;

	initial
	begin
		tab = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
		nv = '{default: 8'h00};
		t = LOAD_T;
		{step, saves, skips, loads, wr, busy_dev_oe, sel_q, we_q, busy_q} = {32'h0, 96'h0, 5'h07};
	end

	task automatic nv_cycle(input logic save);
		if (save)
		begin
			nv = '{default: 8'hFF};
			nv = ram;
			saves++;
		end
		else
		begin
			ram = '{default: 8'h00};
			ram = nv;
			loads++;
		end
		t = save ? SAVE_T : LOAD_T;
		busy_dev_oe <= save;
		wr = 0;
		step = 0;
	endtask

	assign dq_dev_oe = !sel_n && !oe_n && we_n && busy && t == 0;
	assign dq_dev = ram[addr];

	always @(posedge clk)
	begin
		if (t > 0)
		begin
			t--;
			if (t == 0)
				busy_dev_oe <= 1'b0;
		end
		else if (busy_q && !busy)
		begin
			if (wr)
				nv_cycle(1'b1);
			else
				skips++;
		end
		else if (sel_n && !sel_q && busy)
		begin
			if (!we_q)
			begin
				ram[addr] = dq_host;
				wr = 1;
				step = 0;
			end
			else if (step == 5 && (addr == SEQ_ADDR_SAVE || addr == SEQ_ADDR_RELOAD))
				nv_cycle(addr == SEQ_ADDR_SAVE);
			else if (step < 5 && addr == tab[step])
				step++;
			else
				step = int'(addr == SEQ_ADDR_0);
		end
		sel_q = sel_n;
		we_q = we_n;
		busy_q = busy;
	end
endmodule // nvsram_dev_model
`default_nettype wire

// ---- tb/nvsram_host_tb_top.sv ----
`default_nettype none
module nvsram_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import nvsram_pkg::*;
	logic        CORE_CLK = 0, RST = 1, CMD_VALID = 0;
	logic [2:0]  CMD_OP = 0;
	logic [12:0] CMD_ADDR = 0, MEM_ADDR;
	logic [7:0]  CMD_WDATA = 0, RSP_RDATA, MEM_DQ_OUT, dq_dev, dq_in, rdata;
	logic        CMD_READY, RSP_VALID, MEM_SEL_N, MEM_WE_N, MEM_OE_N, MEM_DQ_OE;
	logic        BUSY_LINE_OE, BUSY_LINE_OUT, dq_dev_oe, busy_dev_oe, busy;
	int          err_count = 0, cmp_count = 0;

	assign busy = !((BUSY_LINE_OE && !BUSY_LINE_OUT) || busy_dev_oe);
	assign dq_in = dq_dev_oe ? dq_dev : MEM_DQ_OE ? MEM_DQ_OUT : ~dq_dev;

	nvsram_host #(.POWERUP_CYC(20), .SAVE_CYC(50)) DUT (.CORE_CLK, .RST, .CMD_VALID, .CMD_READY,
		.CMD_OP, .CMD_ADDR, .CMD_WDATA, .RSP_VALID, .RSP_RDATA, .MEM_ADDR, .MEM_SEL_N,
		.MEM_WE_N, .MEM_OE_N, .MEM_DQ_IN(dq_in), .MEM_DQ_OUT, .MEM_DQ_OE,
		.BUSY_LINE_IN(busy), .BUSY_LINE_OUT, .BUSY_LINE_OE);
	nvsram_dev_model DEV (.clk(CORE_CLK), .addr(MEM_ADDR), .sel_n(MEM_SEL_N), .we_n(MEM_WE_N),
		.oe_n(MEM_OE_N), .dq_host(MEM_DQ_OUT), .busy(busy), .dq_dev(dq_dev),
		.dq_dev_oe(dq_dev_oe), .busy_dev_oe(busy_dev_oe));

	initial forever #20 CORE_CLK = ~CORE_CLK;

	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cmd(input logic [2:0] op, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		CMD_VALID <= 1'b1;
		CMD_OP <= op;
		CMD_ADDR <= a;
		CMD_WDATA <= d;
		@(posedge CORE_CLK);
		while (CMD_READY !== 1'b1 && n < 3000)
		begin
			n++;
			@(posedge CORE_CLK);
		end
		CMD_VALID <= 1'b0;
		@(posedge CORE_CLK);
		while (RSP_VALID !== 1'b1 && n < 3000)
		begin
			n++;
			@(posedge CORE_CLK);
		end
		rdata = RSP_RDATA;
		cmp(32'(n < 3000), 32'h1);
	endtask

	task t_rw;
		cmd(OP_WRITE, 13'h1FFF, 8'hA5);
		cmd(OP_WRITE, 13'h0000, 8'h5A);
		cmd(OP_WRITE, 13'h0123, 8'h3C);
		cmd(OP_READ, 13'h1FFF, 8'h00);
		cmp(rdata, 8'hA5);
		cmd(OP_READ, 13'h0000, 8'h00);
		cmp(rdata, 8'h5A);
		$display("test rw done");
	endtask

	task t_save;
		cmd(OP_SAVE, 13'h0000, 8'h00);
		cmp(DEV.saves, 1);
		cmp(DEV.nv[13'h0123], 8'h3C);
		cmd(OP_SAVE, 13'h0000, 8'h00);
		cmp(DEV.saves, 2);
		$display("test save done");
	endtask

	task t_reload;
		cmd(OP_WRITE, 13'h0123, 8'hC3);
		cmd(OP_RELOAD, 13'h0000, 8'h00);
		cmp(DEV.loads, 1);
		cmd(OP_READ, 13'h0123, 8'h00);
		cmp(rdata, 8'h3C);
		$display("test reload done");
	endtask

	task t_hw;
		cmd(OP_HWSAVE, 13'h0000, 8'h00);
		cmp(DEV.skips, 1);
		cmd(OP_WRITE, 13'h0123, 8'h77);
		cmd(OP_HWSAVE, 13'h0000, 8'h00);
		cmp(DEV.saves, 3);
		cmp(DEV.nv[13'h0123], 8'h77);
		cmd(OP_READ, 13'h0123, 8'h00);
		cmp(rdata, 8'h77);
		$display("test hw save done");
	endtask

	initial
	begin
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		t_rw;
		t_save;
		t_reload;
		t_hw;
		final_report;
	end

	initial
	begin
		#(40 * 10000);
		err_count++;
		final_report;
	end
endmodule // nvsram_host_tb_top
`default_nettype wire
